// >>> common/mdmac_defs.vh
// mdmac_defs.vh: shared constants for the multichannel dma controller
// assumes inclusion by bare name from the logic files
`ifndef MDMAC_DEFS_VH
`define MDMAC_DEFS_VH

// address and count widths
`define MDMAC_AW 32
`define MDMAC_CW 16
// channel numbering: 0-3 external, 4-7 link tx, 8-11 link rx, 12-13 slave inbound
`define MDMAC_NCH 14
`define MDMAC_CH_EXT0 4'h0
`define MDMAC_CH_LTX0 4'h4
`define MDMAC_CH_LRX0 4'h8
`define MDMAC_CH_SLV0 4'hc
// external channel protocol modes
`define MDMAC_MODE_MASTER 1'b0
`define MDMAC_MODE_HSHAKE 1'b1
// link ports carry quad words only
`define MDMAC_QUAD_W 128
// address step of one quad word in 32-bit words
`define MDMAC_QUAD_STEP 32'h00000004
// channel setup reset values
`define MDMAC_RST_ADDR 32'h00000000
`define MDMAC_RST_CNT 16'h0000

`endif

// >>> logic/mdmac_agen.v
// mdmac_agen.v: two-dimensional address generator for one dma channel
// assumes setup is loaded only while the channel is idle
`timescale 1ns/1ps
`include "mdmac_defs.vh"

module mdmac_agen (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // setup load
    input wire load_in,
    input wire [`MDMAC_AW-1:0] x_index_in,
    input wire [`MDMAC_CW-1:0] x_count_in,
    input wire [`MDMAC_AW-1:0] x_modify_in,
    input wire [`MDMAC_CW-1:0] y_count_in,
    input wire [`MDMAC_AW-1:0] y_modify_in,
    // element step
    input wire step_in,
    // status
    output wire [`MDMAC_AW-1:0] addr_out,
    output wire active_out,
    output wire last_out
);

    reg [`MDMAC_AW-1:0] x_index_ff;
    reg [`MDMAC_AW-1:0] x_modify_ff;
    reg [`MDMAC_AW-1:0] y_modify_ff;
    reg [`MDMAC_CW-1:0] x_count_ff;
    reg [`MDMAC_CW-1:0] x_reload_ff;
    reg [`MDMAC_CW-1:0] y_count_ff;
    reg active_ff;

    assign addr_out = x_index_ff;
    assign active_out = active_ff;
    // a y count of zero or one means a plain linear block
    assign last_out = active_ff && (x_count_ff == 16'h0001) && (y_count_ff <= 16'h0001);

    // one index; count and modify per dimension
    always @(posedge clk_in) begin
        if (rst_in) begin
            x_index_ff <= `MDMAC_RST_ADDR;
            x_modify_ff <= `MDMAC_RST_ADDR;
            y_modify_ff <= `MDMAC_RST_ADDR;
            x_count_ff <= `MDMAC_RST_CNT;
            x_reload_ff <= `MDMAC_RST_CNT;
            y_count_ff <= `MDMAC_RST_CNT;
            active_ff <= 1'b0;
        end else if (load_in) begin
            x_index_ff <= x_index_in;
            x_modify_ff <= x_modify_in;
            y_modify_ff <= y_modify_in;
            x_count_ff <= x_count_in;
            x_reload_ff <= x_count_in;
            y_count_ff <= y_count_in;
            active_ff <= (x_count_in != 16'h0000);
        end else if (step_in && active_ff) begin
            if (x_count_ff != 16'h0001) begin
                x_index_ff <= x_index_ff + x_modify_ff;
                x_count_ff <= x_count_ff - 16'h0001;
            end else if (y_count_ff > 16'h0001) begin
                x_index_ff <= x_index_ff + y_modify_ff;
                x_count_ff <= x_reload_ff;
                y_count_ff <= y_count_ff - 16'h0001;
            end else begin
                x_count_ff <= 16'h0000;
                active_ff <= 1'b0;
            end
        end
    end

endmodule // mdmac_agen

// >>> logic/mdmac_rrarb.v
// mdmac_rrarb.v: four-way rotating priority arbiter
// assumes requests are levels on the local clock
`timescale 1ns/1ps

module mdmac_rrarb (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // requests and grant
    input wire [3:0] req_in,
    input wire take_in,
    output reg [3:0] grant_out
);

    reg [1:0] last_ff;
    reg [1:0] idx;
    integer i;

    // pick the first requester after the last winner
    always @* begin
        grant_out = 4'h0;
        idx = 2'h0;
        for (i = 4; i >= 1; i = i - 1) begin
            idx = last_ff + i[1:0];
            if (req_in[idx]) begin
                grant_out = 4'h0;
                grant_out[idx] = 1'b1;
            end
        end
    end

    // remember winner so it drops to lowest priority
    always @(posedge clk_in) begin
        if (rst_in) begin
            last_ff <= 2'h3;
        end else if (take_in) begin
            case (grant_out)
                4'h1: last_ff <= 2'h0;
                4'h2: last_ff <= 2'h1;
                4'h4: last_ff <= 2'h2;
                4'h8: last_ff <= 2'h3;
                default: last_ff <= last_ff;
            endcase
        end
    end

endmodule // mdmac_rrarb

// >>> logic/mdmac_top.v
// mdmac_top.v: multichannel dma controller with fourteen channels
// assumes a single internal memory port that accepts one request per cycle
// and setup loaded by the core through the cfg port while the channel idles
`timescale 1ns/1ps
`include "mdmac_defs.vh"

// Overview of operation
// - every channel does linear or 2-d transfers
// - one index, separate x and y count and modify
// - four bidirectional external bus channels
// - external channels: master or handshake mode
// - eight link channels, four tx four rx
// - link channels move quad words only
// - link channels use handshake protocol only
// - rotating priority among link receive channels
// - two slave inbound channels into memory
// - slave inbound only started by bus master
// - requests to uninitialised channels ignored
module mdmac_top (
    // clock and reset
    input wire CLK_IN,
    input wire SYS_RST_IN,
    // channel setup from the core
    input wire CFG_LOAD_IN,
    input wire [3:0] CFG_CH_IN,
    input wire [`MDMAC_AW-1:0] CFG_X_INDEX_IN,
    input wire [`MDMAC_CW-1:0] CFG_X_COUNT_IN,
    input wire [`MDMAC_AW-1:0] CFG_X_MODIFY_IN,
    input wire [`MDMAC_CW-1:0] CFG_Y_COUNT_IN,
    input wire [`MDMAC_AW-1:0] CFG_Y_MODIFY_IN,
    input wire CFG_MODE_IN,
    input wire CFG_DIR_WR_IN,
    // external transfer request lines, asynchronous
    input wire [3:0] EXT_TRANSFER_REQUEST_LINES_IN,
    // link handshake requests, one per link channel
    input wire [3:0] LINK_TX_REQ_IN,
    input wire [3:0] LINK_RX_REQ_IN,
    // slave inbound writes from an external bus master
    input wire [1:0] SLAVE_WR_IN,
    // transfer issued to memory
    output wire XFER_VALID_OUT,
    output wire [3:0] XFER_CH_OUT,
    output wire [`MDMAC_AW-1:0] XFER_ADDR_OUT,
    output wire XFER_WR_OUT,
    output wire XFER_QUAD_OUT,
    // channel status
    output wire [`MDMAC_NCH-1:0] CH_ACTIVE_OUT,
    output wire [`MDMAC_NCH-1:0] CH_DONE_OUT
);

    localparam ST_IDLE = 1'b0;
    localparam ST_ISSUE = 1'b1;

    // per-channel setup bits and status flags
    reg [`MDMAC_NCH-1:0] mode_ff;
    reg [`MDMAC_NCH-1:0] dir_wr_ff;
    reg [`MDMAC_NCH-1:0] done_ff;
    reg [`MDMAC_NCH-1:0] active_ff;
    // two-stage synchroniser for the asynchronous request pins
    reg [3:0] dreq_s1_ff;
    reg [3:0] dreq_s2_ff;
    reg [3:0] dreq_prev_ff;
    reg [3:0] ext_pend_ff;
    // issue stage
    reg state_ff;
    reg xfer_valid_ff;
    reg [3:0] xfer_ch_ff;
    reg [`MDMAC_AW-1:0] xfer_addr_ff;
    reg xfer_wr_ff;
    reg xfer_quad_ff;

    wire [`MDMAC_NCH-1:0] ch_active;
    wire [`MDMAC_NCH-1:0] ch_last;
    wire [`MDMAC_AW-1:0] ch_addr [0:`MDMAC_NCH-1];
    wire [3:0] rx_grant;
    reg [`MDMAC_NCH-1:0] ch_req;
    reg [`MDMAC_NCH-1:0] ch_load;
    reg [`MDMAC_NCH-1:0] ch_step;
    reg [3:0] pick;
    reg pick_ok;
    // one loop index per process so no variable has two drivers
    integer k_load;
    integer k_pend;
    integer k_req;
    integer k_pick;
    integer k_flag;

    // link channels sit between the transmit base and the inbound base
    function mdmac_is_link;
        input [3:0] ch;
        begin
            mdmac_is_link = (ch >= `MDMAC_CH_LTX0) && (ch < `MDMAC_CH_SLV0);
        end
    endfunction

    // link channels force a quad-word step; others take the given modify
    function [`MDMAC_AW-1:0] mdmac_xmod;
        input [3:0] ch;
        input [`MDMAC_AW-1:0] modify;
        begin
            if (mdmac_is_link(ch)) begin
                mdmac_xmod = `MDMAC_QUAD_STEP;
            end else begin
                mdmac_xmod = modify;
            end
        end
    endfunction

    // memory direction per group: rx and inbound write, tx reads
    function mdmac_wr_dir;
        input [3:0] ch;
        input dir_wr;
        begin
            if (ch >= `MDMAC_CH_LRX0) begin
                mdmac_wr_dir = 1'b1;
            end else if (ch >= `MDMAC_CH_LTX0) begin
                mdmac_wr_dir = 1'b0;
            end else begin
                mdmac_wr_dir = dir_wr;
            end
        end
    endfunction

    // setup load decode
    always @* begin
        ch_load = {`MDMAC_NCH{1'b0}};
        // channel numbers 14 and 15 match no slot and are dropped
        for (k_load = 0; k_load < `MDMAC_NCH; k_load = k_load + 1) begin
            ch_load[k_load] = CFG_LOAD_IN && (CFG_CH_IN == k_load[3:0]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < `MDMAC_NCH; g = g + 1) begin : gen_ch
            localparam [31:0] CH_NUM = g;
            mdmac_agen u_agen (
                .clk_in(CLK_IN),
                .rst_in(SYS_RST_IN),
                .load_in(ch_load[g]),
                .x_index_in(CFG_X_INDEX_IN),
                .x_count_in(CFG_X_COUNT_IN),
                .x_modify_in(mdmac_xmod(CH_NUM[3:0], CFG_X_MODIFY_IN)),
                .y_count_in(CFG_Y_COUNT_IN),
                .y_modify_in(CFG_Y_MODIFY_IN),
                .step_in(ch_step[g]),
                .addr_out(ch_addr[g]),
                .active_out(ch_active[g]),
                .last_out(ch_last[g])
            );
        end
    endgenerate

    mdmac_rrarb u_rxarb (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .req_in(ch_req[11:8]),
        .take_in(pick_ok && pick[3:2] == 2'b10),
        .grant_out(rx_grant)
    );

    // synchronise external request pins
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            dreq_s1_ff <= 4'h0;
            dreq_s2_ff <= 4'h0;
            dreq_prev_ff <= 4'h0;
        end else begin
            dreq_s1_ff <= EXT_TRANSFER_REQUEST_LINES_IN;
            dreq_s2_ff <= dreq_s1_ff;
            dreq_prev_ff <= dreq_s2_ff;
        end
    end

    // handshake requests held pending until served
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            ext_pend_ff <= 4'h0;
        end else begin
            for (k_pend = 0; k_pend < 4; k_pend = k_pend + 1) begin
                if (dreq_s2_ff[k_pend] && !dreq_prev_ff[k_pend] && ch_active[k_pend] &&
                    mode_ff[k_pend] == `MDMAC_MODE_HSHAKE) begin
                    ext_pend_ff[k_pend] <= 1'b1;
                end else if (ch_step[k_pend]) begin
                    ext_pend_ff[k_pend] <= 1'b0;
                end
            end
        end
    end

    // request per channel group
    always @* begin
        ch_req = {`MDMAC_NCH{1'b0}};
        for (k_req = 0; k_req < 4; k_req = k_req + 1) begin
            // master runs freely, handshake waits for request
            ch_req[k_req] = ch_active[k_req] &&
                ((mode_ff[k_req] == `MDMAC_MODE_MASTER) || ext_pend_ff[k_req]);
            ch_req[4 + k_req] = ch_active[4 + k_req] && LINK_TX_REQ_IN[k_req];
            ch_req[8 + k_req] = ch_active[8 + k_req] && LINK_RX_REQ_IN[k_req];
        end
        // only an external master write starts these
        ch_req[12] = ch_active[12] && SLAVE_WR_IN[0];
        ch_req[13] = ch_active[13] && SLAVE_WR_IN[1];
    end

    // fixed order between groups: slave, link rx, link tx, external
    always @* begin
        pick = 4'h0;
        pick_ok = 1'b0;
        if (state_ff == ST_IDLE) begin
            if (ch_req[12]) begin
                pick = `MDMAC_CH_SLV0;
                pick_ok = 1'b1;
            end else if (ch_req[13]) begin
                pick = 4'hd;
                pick_ok = 1'b1;
            end else if (|rx_grant) begin
                pick_ok = 1'b1;
                case (rx_grant)
                    4'h1: pick = 4'h8;
                    4'h2: pick = 4'h9;
                    4'h4: pick = 4'ha;
                    default: pick = 4'hb;
                endcase
            end else begin
                // transmit then external channels, lowest index first
                for (k_pick = 3; k_pick >= 0; k_pick = k_pick - 1) begin
                    if (ch_req[k_pick]) begin
                        pick = k_pick[3:0];
                        pick_ok = 1'b1;
                    end
                end
                // a transmit request overrides any external pick
                for (k_pick = 7; k_pick >= 4; k_pick = k_pick - 1) begin
                    if (ch_req[k_pick]) begin
                        pick = k_pick[3:0];
                        pick_ok = 1'b1;
                    end
                end
            end
        end
    end

    // element step on the picked channel
    always @* begin
        ch_step = {`MDMAC_NCH{1'b0}};
        ch_step[pick] = pick_ok;
    end

    // issue stage: one element then one recovery cycle
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state_ff <= ST_IDLE;
            xfer_valid_ff <= 1'b0;
            xfer_ch_ff <= 4'h0;
            xfer_addr_ff <= `MDMAC_RST_ADDR;
            xfer_wr_ff <= 1'b0;
            xfer_quad_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    xfer_valid_ff <= pick_ok;
                    if (pick_ok) begin
                        state_ff <= ST_ISSUE;
                        xfer_ch_ff <= pick;
                        xfer_addr_ff <= ch_addr[pick];
                        xfer_wr_ff <= mdmac_wr_dir(pick, dir_wr_ff[pick]);
                        xfer_quad_ff <= mdmac_is_link(pick);
                    end
                end
                ST_ISSUE: begin
                    xfer_valid_ff <= 1'b0;
                    state_ff <= ST_IDLE;
                end
                default: begin
                    xfer_valid_ff <= 1'b0;
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // setup bits, activity and done flags
    always @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            mode_ff <= {`MDMAC_NCH{1'b0}};
            dir_wr_ff <= {`MDMAC_NCH{1'b0}};
            done_ff <= {`MDMAC_NCH{1'b0}};
            active_ff <= {`MDMAC_NCH{1'b0}};
        end else begin
            active_ff <= ch_active;
            for (k_flag = 0; k_flag < `MDMAC_NCH; k_flag = k_flag + 1) begin
                if (ch_step[k_flag] && ch_last[k_flag]) begin
                    done_ff[k_flag] <= 1'b1;
                end else if (ch_load[k_flag]) begin
                    done_ff[k_flag] <= 1'b0;
                end
                if (ch_load[k_flag]) begin
                    mode_ff[k_flag] <= (k_flag < 4) ? CFG_MODE_IN : `MDMAC_MODE_HSHAKE;
                    dir_wr_ff[k_flag] <= CFG_DIR_WR_IN;
                end
            end
        end
    end

    assign XFER_VALID_OUT = xfer_valid_ff;
    assign XFER_CH_OUT = xfer_ch_ff;
    assign XFER_ADDR_OUT = xfer_addr_ff;
    assign XFER_WR_OUT = xfer_wr_ff;
    assign XFER_QUAD_OUT = xfer_quad_ff;
    assign CH_ACTIVE_OUT = active_ff;
    assign CH_DONE_OUT = done_ff;

endmodule // mdmac_top

// >>> verification/mdmac_top_properties.sv
// mdmac_top_properties.sv: port assertions for the multichannel dma controller
// assumes it is bound onto mdmac_top and sees only its ports
`timescale 1ns/1ps

module mdmac_chk (
    // clock and reset
    input logic CLK_IN,
    input logic SYS_RST_IN,
    // requests watched
    input logic CFG_LOAD_IN,
    input logic [3:0] LINK_TX_REQ_IN,
    input logic [3:0] LINK_RX_REQ_IN,
    input logic [1:0] SLAVE_WR_IN,
    // issue and status watched
    input logic XFER_VALID_OUT,
    input logic [3:0] XFER_CH_OUT,
    input logic XFER_WR_OUT,
    input logic XFER_QUAD_OUT,
    input logic [13:0] CH_DONE_OUT
);
    default clocking dcb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // one issue, then one idle cycle
    sequence s_issue;
        XFER_VALID_OUT;
    endsequence
    sequence s_gap;
        !XFER_VALID_OUT;
    endsequence

    issue_gap_a: assert property (s_issue |=> s_gap)
        else $error("issues in adjacent cycles");
    chan_range_a: assert property (s_issue |-> XFER_CH_OUT < 4'he)
        else $error("issue on a channel that does not exist");
    quad_link_a: assert property (s_issue |->
        XFER_QUAD_OUT == (XFER_CH_OUT >= 4'h4 && XFER_CH_OUT <= 4'hb))
        else $error("quad flag does not match channel group");
    rx_writes_a: assert property ((s_issue and (XFER_CH_OUT >= 4'h8)) |-> XFER_WR_OUT)
        else $error("inbound channel did not write memory");
    tx_reads_a: assert property ((s_issue and (XFER_CH_OUT[3:2] == 2'h1)) |-> !XFER_WR_OUT)
        else $error("link transmit channel wrote memory");
    rx_hshake_a: assert property ((s_issue and (XFER_CH_OUT[3:2] == 2'h2)) |->
        ($past(LINK_RX_REQ_IN) & (4'h1 << XFER_CH_OUT[1:0])) != 4'h0)
        else $error("link receive issue without its request");
    tx_hshake_a: assert property ((s_issue and (XFER_CH_OUT[3:2] == 2'h1)) |->
        ($past(LINK_TX_REQ_IN) & (4'h1 << XFER_CH_OUT[1:0])) != 4'h0)
        else $error("link transmit issue without its request");
    slave_start_a: assert property ((s_issue and (XFER_CH_OUT[3:2] == 2'h3)) |->
        ($past(SLAVE_WR_IN) & (2'h1 << XFER_CH_OUT[0])) != 2'h0)
        else $error("inbound issue without a master write");
    done_hold_a: assert property (!CFG_LOAD_IN |=>
        (CH_DONE_OUT & $past(CH_DONE_OUT)) == $past(CH_DONE_OUT))
        else $error("done flag dropped without a reload");
endmodule // mdmac_chk

bind mdmac_top mdmac_chk i_mdmac_chk (
    .CLK_IN(CLK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .CFG_LOAD_IN(CFG_LOAD_IN),
    .LINK_TX_REQ_IN(LINK_TX_REQ_IN),
    .LINK_RX_REQ_IN(LINK_RX_REQ_IN),
    .SLAVE_WR_IN(SLAVE_WR_IN),
    .XFER_VALID_OUT(XFER_VALID_OUT),
    .XFER_CH_OUT(XFER_CH_OUT),
    .XFER_WR_OUT(XFER_WR_OUT),
    .XFER_QUAD_OUT(XFER_QUAD_OUT),
    .CH_DONE_OUT(CH_DONE_OUT)
);

// >>> verification/mdmac_periph_model.sv
// mdmac_periph_model.sv: external peripherals pacing handshake channels
// assumes fire_in is held from one falling edge to the next by the bench
`timescale 1ns/1ps

module mdmac_periph_model (
    // clock
    input logic clk_in,
    // one pulse request per bit
    input logic [3:0] fire_in,
    // request lines towards the controller
    output logic [3:0] req_out = 4'h0
);
    logic [1:0] left [0:3] = '{default: 2'h0};
    logic [3:0] fire_seen = 4'h0;
    integer i;

    // capture the bench pulse away from the falling edge that sets it
    always @(posedge clk_in)
        fire_seen <= fire_in;

    always @(negedge clk_in) begin
        for (i = 0; i < 4; i++) begin
            if (fire_seen[i] && left[i] == 2'h0) begin
                req_out[i] <= 1'b1;
                left[i] <= 2'h3;
            end else if (left[i] != 2'h0) begin
                left[i] <= left[i] - 2'h1;
                req_out[i] <= (left[i] != 2'h1);
            end
        end
    end
endmodule // mdmac_periph_model

// >>> verification/mdmac_top_tb.sv
// mdmac_top_tb.sv: self-checking bench for the dma controller
// assumes mdmac_defs.vh on the include path and the periph model beside it
`timescale 1ns/1ps
`include "mdmac_defs.vh"

module mdmac_top_tb;
    logic clk_in = 1'b0, rst = 1'b1, ld = 1'b0, md = 1'b0, dw = 1'b0;
    logic [3:0] ch = 4'h0, tx = 4'h0, rx = 4'h0, fire = 4'h0, ext;
    logic [1:0] slv = 2'h0;
    logic [31:0] xi = 32'h0, xm = 32'h0, ym = 32'h0;
    logic [15:0] xc = 16'h0, yc = 16'h0;
    logic vld, wr, qd;
    logic [3:0] xch;
    logic [31:0] adr;
    logic [13:0] act, done;
    logic [37:0] q [$];
    int error_cnt = 0, n_checks = 0;

    mdmac_top i_mdmac_top (.CLK_IN(clk_in), .SYS_RST_IN(rst), .CFG_LOAD_IN(ld),
        .CFG_CH_IN(ch), .CFG_X_INDEX_IN(xi), .CFG_X_COUNT_IN(xc), .CFG_X_MODIFY_IN(xm),
        .CFG_Y_COUNT_IN(yc), .CFG_Y_MODIFY_IN(ym), .CFG_MODE_IN(md), .CFG_DIR_WR_IN(dw),
        .EXT_TRANSFER_REQUEST_LINES_IN(ext), .LINK_TX_REQ_IN(tx), .LINK_RX_REQ_IN(rx),
        .SLAVE_WR_IN(slv), .XFER_VALID_OUT(vld), .XFER_CH_OUT(xch), .XFER_ADDR_OUT(adr),
        .XFER_WR_OUT(wr), .XFER_QUAD_OUT(qd), .CH_ACTIVE_OUT(act), .CH_DONE_OUT(done));
    mdmac_periph_model i_mdmac_periph_model (.clk_in(clk_in), .fire_in(fire), .req_out(ext));

    // 100 MHz clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // record every issue while it stands
    always @(negedge clk_in) begin
        if (vld === 1'b1)
            q.push_back({xch, adr, wr, qd});
    end

    task automatic cmp_vec(input string what, input logic [37:0] exp, input logic [37:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic load(input logic [3:0] c, input logic [31:0] i, input logic [15:0] x,
        input logic [31:0] m, input logic [15:0] y, input logic [31:0] n, input logic h,
        input logic w);
        @(negedge clk_in);
        {ch, xi, xc, xm, yc, ym, md, dw, ld} = {c, i, x, m, y, n, h, w, 1'b1};
        @(negedge clk_in);
        ld = 1'b0;
    endtask

    task automatic get_issue(output logic [37:0] e);
        for (int k = 0; k < 60 && q.size() == 0; k++)
            @(negedge clk_in);
        if (q.size() == 0)
            cmp_vec("issue present", 38'h1, 38'h0);
        e = (q.size() == 0) ? '1 : q.pop_front();
    endtask

    task automatic expect_issue(input logic [3:0] c, input logic [31:0] a, input logic w,
        input logic f);
        logic [37:0] e;
        get_issue(e);
        cmp_vec("issue", {c, a, w, f}, e);
    endtask

    task automatic expect_none(input int n);
        repeat (n) @(negedge clk_in);
        cmp_vec("stray issues", 38'h0, 38'(q.size()));
        q.delete();
    endtask

    task automatic link_linear();
        load(4'h8, 32'h100, 16'h2, 32'h7, 16'h1, 32'h0, 1'b0, 1'b0);
        rx = 4'h1;
        expect_issue(4'h8, 32'h100, 1'b1, 1'b1);
        expect_issue(4'h8, 32'h104, 1'b1, 1'b1);
        expect_none(10);
        cmp_vec("done", 38'h1, {37'h0, done[8]});
        cmp_vec("active", 38'h0, {37'h0, act[8]});
        rx = 4'h0;
    endtask

    task automatic ext_2d();
        load(4'h1, 32'h1000, 16'h2, 32'h1, 16'h2, 32'h10, `MDMAC_MODE_MASTER, 1'b0);
        expect_issue(4'h1, 32'h1000, 1'b0, 1'b0);
        expect_issue(4'h1, 32'h1001, 1'b0, 1'b0);
        expect_issue(4'h1, 32'h1011, 1'b0, 1'b0);
        expect_issue(4'h1, 32'h1012, 1'b0, 1'b0);
        expect_none(10);
        cmp_vec("done", 38'h1, {37'h0, done[1]});
    endtask

    task automatic ext_hshake();
        fire = 4'h8;
        @(negedge clk_in);
        fire = 4'h0;
        expect_none(20);
        load(4'h2, 32'h200, 16'h1, 32'h1, 16'h1, 32'h0, `MDMAC_MODE_HSHAKE, 1'b1);
        expect_none(10);
        cmp_vec("active waiting", 38'h1, {37'h0, act[2]});
        fire = 4'h4;
        @(negedge clk_in);
        fire = 4'h0;
        expect_issue(4'h2, 32'h200, 1'b1, 1'b0);
    endtask

    task automatic rx_rotate();
        logic [37:0] e;
        logic [3:0] seen;
        for (int c = 8; c < 12; c++)
            load(4'(c), 32'h300, 16'h2, 32'h0, 16'h1, 32'h0, 1'b0, 1'b0);
        rx = 4'hf;
        seen = 4'h0;
        for (int k = 0; k < 8; k++) begin
            get_issue(e);
            if (k < 4)
                seen = seen | (4'h1 << e[35:34]);
        end
        cmp_vec("first rx round", 38'hf, {34'h0, seen});
        expect_none(10);
        rx = 4'h0;
    endtask

    task automatic slave_and_tx();
        for (int j = 0; j < 2; j++) begin
            load(4'hc + 4'(j), 32'h400, 16'h1, 32'h1, 16'h1, 32'h0, 1'b0, 1'b0);
            expect_none(10);
            slv = 2'h1 << j;
            expect_issue(4'hc + 4'(j), 32'h400, 1'b1, 1'b0);
            slv = 2'h0;
        end
        load(4'h5, 32'h500, 16'h1, 32'h1, 16'h1, 32'h0, 1'b0, 1'b1);
        tx = 4'h2;
        expect_issue(4'h5, 32'h500, 1'b0, 1'b1);
        tx = 4'h0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(negedge clk_in);
        rst = 1'b0;
        cmp_vec("active after reset", 38'h0, {24'h0, act});
        link_linear();
        ext_2d();
        ext_hshake();
        rx_rotate();
        slave_and_tx();
        complete_run();
    end
    // watchdog
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule // mdmac_top_tb
